// ===== hdl/wmx_exec.sv
/*
 Executor for the general word copy family: accumulators, pointers, special
 registers, program and data memory copies, and test flag copies.
 Assumes the core decoder issues one command at a time when ready is high,
 and that memories answer reads within the cycle the registered request is out.
*/
`timescale 1ns/1ps
`include "wmx_defines.svh"

// How it works
// - Next-accumulator modifier steps pointer before transfer
// - Accumulator loads refresh the accumulator zero flag
// - Shift amount keeps only four bits
// - Shift amount stores as four-bit word
// - Multiplier from accumulator selects signed mode
// - Multiplier from memory selects signed mode
// - Signed mode clears unsigned flag bit one
// - Pointer load from memory keeps six bits
// - Immediate pointer load uses five-bit constant
// - Table lookup writes program word to accumulator
// - Program word at accumulator stored to memory
// - Chain length loads and stores as byte
// - Status register loads and stores whole
// - Stack top loads and stores whole word
// - Data pointer stores; product high moves freely
// - Test flag copies to and from memory flags
// - Condition sets test flag one else zero
// - Sixteen-bit immediates load accumulator, multiplier, index
module wmx_exec
    import wmx_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command from the core decoder
    input wire logic cmd_valid,
    input wire wmx_cmd_t cmd,
    input wire logic cond_true,
    output logic cmd_ready,
    output logic done,
    // Data memory
    output wmx_mem_t dmem_req,
    input wire logic [`WMX_WORD_W-1:0] dmem_rdata,
    input wire logic dflag_rdata,
    // Program memory
    output logic pmem_rd,
    output logic [`WMX_WORD_W-1:0] pmem_addr,
    input wire logic [`WMX_WORD_W-1:0] pmem_rdata,
    // Outside-held register values for stores, and the stack top write-out for loads
    input wire logic [`WMX_WORD_W-1:0] data_pointer_reg,
    input wire logic [`WMX_WORD_W-1:0] stack_top_in,
    output logic stack_top_wr,
    output logic [`WMX_WORD_W-1:0] stack_top_entry,
    // Visible register state
    output logic [`WMX_WORD_W-1:0] status_reg,
    output logic [`WMX_WORD_W-1:0] multiplier_operand_reg,
    output logic [`WMX_WORD_W-1:0] product_high_reg,
    output logic [`WMX_SHIFT_W-1:0] shift_amount_reg,
    output logic [`WMX_CHAIN_W-1:0] chain_length_reg,
    output logic [`WMX_PC_W-1:0] pc_reg
);

    // ==========================================================
    // Storage
    // ==========================================================
    logic [`WMX_WORD_W-1:0] acc_r [0:2*`WMX_NUM_ACC-1]; // Accumulators, alternates above
    logic [`WMX_AP_W-1:0] ap_r [0:`WMX_NUM_ACC-1]; // Accumulator pointers
    logic [`WMX_WORD_W-1:0] idx_r [0:`WMX_NUM_IDX-1]; // Index registers
    logic [`WMX_WORD_W-1:0] stat_r; // Status
    logic [`WMX_WORD_W-1:0] mr_r; // Multiplier operand
    logic [`WMX_WORD_W-1:0] ph_r; // Product high
    logic [`WMX_SHIFT_W-1:0] sv_r; // Shift amount
    logic [`WMX_CHAIN_W-1:0] str_r; // Chain length
    logic [`WMX_PC_W-1:0] pc_r; // Program counter
    logic [`WMX_WORD_W-1:0] tos_r; // Stack top shadow
    logic tos_wr_r; // Stack top write strobe
    wmx_state_t state_r; // Phase
    wmx_cmd_t cmd_r; // Held command
    logic [`WMX_AP_W-1:0] ptr_r; // Pointer used for this copy
    wmx_mem_t mem_r; // Memory request
    logic prd_r; // Program memory read
    logic [`WMX_WORD_W-1:0] paddr_r; // Program memory address
    logic done_r; // Completion pulse
    logic ready_r; // Command ready, registered so the port comes from a flop

    // ==========================================================
    // Functions
    // ==========================================================
    // Accumulator slot: pointer low bits pick word, alt bit picks bank
    function automatic logic [2:0] acc_slot(input logic [`WMX_AP_W-1:0] p, input logic alt);
        acc_slot = {alt, p[1:0]};
    endfunction

    // Status with fresh accumulator flags; only zero flag is tracked here
    function automatic logic [`WMX_WORD_W-1:0] with_flags(input logic [`WMX_WORD_W-1:0] s,
                                                          input logic [`WMX_WORD_W-1:0] v);
        logic [`WMX_WORD_W-1:0] t;
        t = s;
        t[`WMX_STAT_ZF_BIT] = (v == 16'h0000);
        with_flags = t;
    endfunction

    // Replace one test flag, leaving every other bit
    function automatic logic [`WMX_WORD_W-1:0] put_tf(input logic [`WMX_WORD_W-1:0] s,
                                                      input logic sel, input logic b);
        logic [`WMX_WORD_W-1:0] t;
        t = s;
        if (sel) begin
            t[`WMX_STAT_TF2_BIT] = b;
        end else begin
            t[`WMX_STAT_TF1_BIT] = b;
        end
        put_tf = t;
    endfunction

    // ==========================================================
    // Decode
    // ==========================================================
    // Stepped pointer; stepping happens before any use
    wire [`WMX_AP_W-1:0] ap_now = ap_r[cmd_r.acc_sel];
    wire [`WMX_AP_W-1:0] ap_step = cmd_r.next_dn ? ap_now - 6'h01 : ap_now + 6'h01;
    wire [`WMX_AP_W-1:0] ap_use = cmd_r.next_en ? ap_step : ap_now;
    wire [2:0] slot_sel = acc_slot(ptr_r, cmd_r.use_alt);
    wire [2:0] slot_oth = acc_slot(ptr_r, ~cmd_r.use_alt);
    wire [`WMX_WORD_W-1:0] acc_val = acc_r[slot_sel];
    wire [`WMX_WORD_W-1:0] tf_word = cmd_r.tf_sel ? {15'h0000, stat_r[`WMX_STAT_TF2_BIT]}
                                                  : {15'h0000, stat_r[`WMX_STAT_TF1_BIT]};
    // Reads that need a memory answer before the write-back
    wire needs_read = (cmd_r.op == WMX_ACC_LD_MEM) || (cmd_r.op == WMX_IDX_LD_MEM) ||
                      (cmd_r.op == WMX_PH_LD_MEM) || (cmd_r.op == WMX_MR_LD_MEM) ||
                      (cmd_r.op == WMX_AP_LD_MEM) || (cmd_r.op == WMX_STAT_LD_MEM) ||
                      (cmd_r.op == WMX_SV_LD_MEM) || (cmd_r.op == WMX_TOS_LD_MEM) ||
                      (cmd_r.op == WMX_CHAIN_LD_MEM) || (cmd_r.op == WMX_TF_LD_FLAG);
    wire needs_prog = (cmd_r.op == WMX_TABLE_TO_ACC) || (cmd_r.op == WMX_TABLE_TO_MEM);

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Idle takes a command, prep steps pointer and issues reads, xfer writes back
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= WMX_IDLE;
            cmd_r <= '0;
            done_r <= 1'b0;
            ready_r <= 1'b1;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                WMX_IDLE: begin
                    if (cmd_valid) begin
                        cmd_r <= cmd;
                        ready_r <= 1'b0;
                        state_r <= WMX_PREP;
                    end
                end
                WMX_PREP: state_r <= WMX_XFER;
                WMX_XFER: begin
                    done_r <= 1'b1;
                    ready_r <= 1'b1;
                    state_r <= WMX_IDLE;
                end
                default: begin
                    state_r <= WMX_IDLE;
                end
            endcase
        end
    end

    // Pointer update in prep, latched for use in xfer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `WMX_NUM_ACC; i++) begin
                ap_r[i] <= '0;
            end
            ptr_r <= '0;
        end else if (state_r == WMX_PREP) begin
            ap_r[cmd_r.acc_sel] <= ap_use;
            ptr_r <= ap_use;
        end else if (state_r == WMX_XFER && cmd_r.op == WMX_AP_LD_MEM) begin
            ap_r[cmd_r.acc_sel] <= dmem_rdata[`WMX_AP_LOAD_W-1:0];
        end else if (state_r == WMX_XFER && cmd_r.op == WMX_AP_LD_IMM) begin
            ap_r[cmd_r.acc_sel] <= {1'b0, cmd_r.imm[`WMX_AP_IMM_W-1:0]};
        end
    end

    // Memory requests: reads in prep, writes in xfer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_r <= '0;
            prd_r <= 1'b0;
            paddr_r <= '0;
        end else begin
            mem_r.rd <= (state_r == WMX_PREP) && needs_read;
            mem_r.flag <= ((state_r == WMX_PREP) && cmd_r.op == WMX_TF_LD_FLAG) ||
                          ((state_r == WMX_XFER) && cmd_r.op == WMX_TF_ST_FLAG);
            mem_r.addr <= cmd_r.imm;
            prd_r <= (state_r == WMX_PREP) && needs_prog;
            paddr_r <= acc_r[acc_slot(ap_use, cmd_r.use_alt)];
            mem_r.wr <= 1'b0;
            if (state_r == WMX_XFER) begin
                mem_r.wr <= 1'b1;
                case (cmd_r.op)
                    WMX_ACC_ST_MEM: mem_r.wdata <= acc_val;
                    WMX_IDX_ST_MEM: mem_r.wdata <= idx_r[cmd_r.idx_sel];
                    WMX_TABLE_TO_MEM: mem_r.wdata <= pmem_rdata;
                    WMX_PH_ST_MEM: mem_r.wdata <= ph_r;
                    WMX_MR_ST_MEM: mem_r.wdata <= mr_r;
                    WMX_STAT_ST_MEM: mem_r.wdata <= stat_r;
                    WMX_CHAIN_ST_MEM: mem_r.wdata <= {8'h00, str_r};
                    WMX_DP_ST_MEM: mem_r.wdata <= data_pointer_reg;
                    WMX_SV_ST_MEM: mem_r.wdata <= {12'h000, sv_r};
                    WMX_AP_ST_MEM: mem_r.wdata <= {10'h000, ap_r[cmd_r.acc_sel]};
                    WMX_TOS_ST_MEM: mem_r.wdata <= stack_top_in;
                    WMX_TF_ST_FLAG: mem_r.wdata <= tf_word;
                    default: mem_r.wr <= 1'b0;
                endcase
            end
        end
    end

    // Write-back of accumulators, index and special registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2*`WMX_NUM_ACC; i++) begin
                acc_r[i] <= '0;
            end
            for (int i = 0; i < `WMX_NUM_IDX; i++) begin
                idx_r[i] <= '0;
            end
            stat_r <= `WMX_STAT_RST;
            mr_r <= '0;
            ph_r <= '0;
            sv_r <= '0;
            str_r <= '0;
            tos_r <= '0;
            tos_wr_r <= 1'b0;
        end else begin
            tos_wr_r <= 1'b0;
            if (state_r == WMX_XFER) begin
                case (cmd_r.op)
                    WMX_ACC_LD_MEM: begin
                        acc_r[slot_sel] <= dmem_rdata;
                        stat_r <= with_flags(stat_r, dmem_rdata);
                    end
                    WMX_ACC_LD_IMM: begin
                        acc_r[slot_sel] <= cmd_r.imm;
                        stat_r <= with_flags(stat_r, cmd_r.imm);
                    end
                    WMX_ACC_FROM_ALT: begin
                        acc_r[slot_sel] <= acc_r[slot_oth];
                        stat_r <= with_flags(stat_r, acc_r[slot_oth]);
                    end
                    WMX_ALT_FROM_ACC: begin
                        acc_r[slot_oth] <= acc_val;
                        stat_r <= with_flags(stat_r, acc_val);
                    end
                    WMX_ACC_FROM_PH: begin
                        acc_r[slot_sel] <= ph_r;
                        stat_r <= with_flags(stat_r, ph_r);
                    end
                    WMX_TABLE_TO_ACC: begin
                        acc_r[slot_sel] <= pmem_rdata;
                        stat_r <= with_flags(stat_r, pmem_rdata);
                    end
                    WMX_MR_LD_IMM: mr_r <= cmd_r.imm;
                    WMX_MR_FROM_ACC: begin
                        mr_r <= acc_val;
                        stat_r[`WMX_STAT_UM_BIT] <= 1'b0;
                    end
                    WMX_MR_LD_MEM: begin
                        mr_r <= dmem_rdata;
                        stat_r[`WMX_STAT_UM_BIT] <= 1'b0;
                    end
                    WMX_SV_FROM_ACC: sv_r <= acc_val[`WMX_SHIFT_W-1:0];
                    WMX_SV_LD_MEM: sv_r <= dmem_rdata[`WMX_SHIFT_W-1:0];
                    WMX_SV_LD_IMM: sv_r <= cmd_r.imm[`WMX_SHIFT_W-1:0];
                    WMX_PH_FROM_ACC: ph_r <= acc_val;
                    WMX_PH_LD_MEM: ph_r <= dmem_rdata;
                    WMX_IDX_LD_MEM: idx_r[cmd_r.idx_sel] <= dmem_rdata;
                    WMX_IDX_LD_IMM: idx_r[cmd_r.idx_sel] <= cmd_r.imm;
                    WMX_IDX_FROM_FIVE: idx_r[cmd_r.idx_sel] <= idx_r[5];
                    WMX_STAT_LD_MEM: stat_r <= dmem_rdata;
                    WMX_CHAIN_LD_MEM: str_r <= dmem_rdata[`WMX_CHAIN_W-1:0];
                    WMX_CHAIN_LD_IMM: str_r <= cmd_r.imm[`WMX_CHAIN_W-1:0];
                    WMX_TOS_LD_MEM: begin
                        tos_r <= dmem_rdata;
                        tos_wr_r <= 1'b1;
                    end
                    WMX_TF_LD_FLAG: stat_r <= put_tf(stat_r, cmd_r.tf_sel, dflag_rdata);
                    WMX_TF_FROM_COND: stat_r <= put_tf(stat_r, cmd_r.tf_sel, cond_true);
                    default: tos_wr_r <= 1'b0;
                endcase
            end
        end
    end

    // Program counter steps by the instruction's word count at the end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pc_r <= '0;
        end else if (state_r == WMX_XFER) begin
            pc_r <= pc_r + {14'h0000, cmd_r.words};
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign cmd_ready = ready_r;
    assign done = done_r;
    assign dmem_req = mem_r;
    assign pmem_rd = prd_r;
    assign pmem_addr = paddr_r;
    assign stack_top_wr = tos_wr_r;
    assign stack_top_entry = tos_r;
    assign status_reg = stat_r;
    assign multiplier_operand_reg = mr_r;
    assign product_high_reg = ph_r;
    assign shift_amount_reg = sv_r;
    assign chain_length_reg = str_r;
    assign pc_reg = pc_r;

endmodule

// ===== pkg/wmx_defines.svh
/*
 Constants for the word copy executor: widths, field positions, reset values.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef WMX_DEFINES_SVH
`define WMX_DEFINES_SVH
`define WMX_WORD_W 16
`define WMX_AP_W 6
`define WMX_AP_LOAD_W 6
`define WMX_AP_IMM_W 5
`define WMX_SHIFT_W 4
`define WMX_CHAIN_W 8
`define WMX_NUM_ACC 4
`define WMX_NUM_IDX 8
`define WMX_PC_W 16
`define WMX_STAT_UM_BIT 1
`define WMX_STAT_ZF_BIT 2
`define WMX_STAT_TF1_BIT 4
`define WMX_STAT_TF2_BIT 5
`define WMX_STAT_RST 16'h0000
`define WMX_FLAGS_W 4
`endif

// ===== pkg/wmx_pkg.sv
/*
 Types for the word copy executor: operation codes and carrier structs.
 Assumes the defines header is on the include path.
*/
`include "wmx_defines.svh"
package wmx_pkg;
    // Copy operation selected by the core decoder
    typedef enum logic [5:0] {
        WMX_NOP = 6'h00,
        WMX_ACC_LD_MEM = 6'h01,
        WMX_ACC_ST_MEM = 6'h02,
        WMX_ACC_LD_IMM = 6'h03,
        WMX_MR_LD_IMM = 6'h04,
        WMX_ACC_FROM_ALT = 6'h05,
        WMX_ALT_FROM_ACC = 6'h06,
        WMX_ACC_FROM_PH = 6'h07,
        WMX_SV_FROM_ACC = 6'h08,
        WMX_PH_FROM_ACC = 6'h09,
        WMX_MR_FROM_ACC = 6'h0A,
        WMX_TABLE_TO_ACC = 6'h0B,
        WMX_IDX_ST_MEM = 6'h0C,
        WMX_IDX_LD_MEM = 6'h0D,
        WMX_IDX_LD_IMM = 6'h0E,
        WMX_IDX_FROM_FIVE = 6'h0F,
        WMX_PH_LD_MEM = 6'h10,
        WMX_MR_LD_MEM = 6'h11,
        WMX_TABLE_TO_MEM = 6'h12,
        WMX_AP_LD_MEM = 6'h13,
        WMX_STAT_LD_MEM = 6'h14,
        WMX_SV_LD_MEM = 6'h15,
        WMX_TOS_LD_MEM = 6'h16,
        WMX_PH_ST_MEM = 6'h17,
        WMX_MR_ST_MEM = 6'h18,
        WMX_STAT_ST_MEM = 6'h19,
        WMX_CHAIN_ST_MEM = 6'h1A,
        WMX_DP_ST_MEM = 6'h1B,
        WMX_SV_ST_MEM = 6'h1C,
        WMX_AP_ST_MEM = 6'h1D,
        WMX_CHAIN_LD_MEM = 6'h1E,
        WMX_TOS_ST_MEM = 6'h1F,
        WMX_TF_LD_FLAG = 6'h20,
        WMX_TF_ST_FLAG = 6'h21,
        WMX_TF_FROM_COND = 6'h22,
        WMX_SV_LD_IMM = 6'h23,
        WMX_CHAIN_LD_IMM = 6'h24,
        WMX_AP_LD_IMM = 6'h25
    } wmx_op_t;

    // Executor phase
    typedef enum logic [1:0] {
        WMX_IDLE = 2'b00,
        WMX_PREP = 2'b01,
        WMX_XFER = 2'b10
    } wmx_state_t;

    // One decoded copy from the core decoder
    typedef struct packed {
        wmx_op_t op;
        logic [1:0] acc_sel;
        logic use_alt;
        logic next_en;
        logic next_dn;
        logic [2:0] idx_sel;
        logic tf_sel;
        logic [1:0] words;
        logic [`WMX_WORD_W-1:0] imm;
    } wmx_cmd_t;

    // Data memory request toward the core memories
    typedef struct packed {
        logic rd;
        logic wr;
        logic flag;
        logic [`WMX_WORD_W-1:0] addr;
        logic [`WMX_WORD_W-1:0] wdata;
    } wmx_mem_t;
endpackage

// ===== verification/wmx_exec_asserts.sv
/*
 Checker for the word copy executor: timing of the answer, the program
 counter, multiplier mode, test flags and the memory-fed loads.
 Assumes the executor is bound in; it sees only the top-level ports.
*/
`timescale 1ns/1ps
module wmx_exec_asserts
    import wmx_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command side
    input wire logic cmd_valid,
    input wire wmx_cmd_t cmd,
    input wire logic cond_true,
    input wire logic cmd_ready,
    input wire logic done,
    // Memories
    input wire wmx_mem_t dmem_req,
    input wire logic [15:0] dmem_rdata,
    input wire logic pmem_rd,
    input wire logic [15:0] pmem_rdata,
    // Register state
    input wire logic stack_top_wr,
    input wire logic [15:0] stack_top_entry,
    input wire logic [15:0] status_reg,
    input wire logic [15:0] multiplier_operand_reg,
    input wire logic [3:0] shift_amount_reg,
    input wire logic [15:0] pc_reg
);
    // ==========
    // Common timing
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Accepted command of one kind
    sequence s_take(wmx_op_t o);
        cmd_valid && cmd_ready && cmd.op == o;
    endsequence
    // Any accepted command
    wire take = cmd_valid && cmd_ready;
    // ==========
    // Properties
    a_done_three: assert property (take |-> ##1 !done ##1 !done ##1 done)
        else $error("done not three cycles after take");
    a_pc_step: assert property (take |-> ##3 pc_reg == $past(pc_reg, 3) + 16'($past(cmd.words, 3)))
        else $error("pc did not advance by words");
    a_um_mem: assert property (s_take(WMX_MR_LD_MEM) |-> ##3 !status_reg[1]
        && multiplier_operand_reg == $past(dmem_rdata, 1)) else $error("multiplier load from memory wrong");
    a_um_acc: assert property (s_take(WMX_MR_FROM_ACC) |-> ##3 !status_reg[1])
        else $error("unsigned flag left set");
    a_tf_cond: assert property (s_take(WMX_TF_FROM_COND) ##0 !cmd.tf_sel |-> ##3
        status_reg[4] == $past(cond_true, 1) && ((status_reg ^ $past(status_reg, 1)) & 16'hFFEF) == 16'h0000)
        else $error("test flag copy wrong");
    a_tos_load: assert property (s_take(WMX_TOS_LD_MEM) |-> ##3 stack_top_wr
        && stack_top_entry == $past(dmem_rdata, 1) ##1 !stack_top_wr) else $error("stack top load wrong");
    a_sv_load: assert property (s_take(WMX_SV_LD_MEM) |-> ##2 dmem_req.rd
        ##1 shift_amount_reg == 4'($past(dmem_rdata, 1))) else $error("shift load wrong");
    a_table_store: assert property (s_take(WMX_TABLE_TO_MEM) |-> ##2 pmem_rd
        ##1 dmem_req.wr && dmem_req.wdata == $past(pmem_rdata, 1)) else $error("table store wrong");
endmodule

bind wmx_exec wmx_exec_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cond_true(cond_true), .cmd_ready(cmd_ready), .done(done), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata), .stack_top_wr(stack_top_wr), .stack_top_entry(stack_top_entry),
    .status_reg(status_reg), .multiplier_operand_reg(multiplier_operand_reg),
    .shift_amount_reg(shift_amount_reg), .pc_reg(pc_reg));

// ===== verification/wmx_exec_tb.sv
/*
 Self-checking bench for the word copy executor: command sequences with
 expected register and memory values. Assumes the memory model beside it.
*/
`timescale 1ns/1ps
module wmx_exec_tb;
    import wmx_pkg::*;
    // ==========
    // Signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0, cond_true = 1'b0;
    wmx_cmd_t cmd = '0;
    logic cmd_ready, done, pmem_rd, stack_top_wr, dflag_rdata;
    wmx_mem_t dmem_req, last_req;
    logic [15:0] dmem_rdata, pmem_addr, pmem_rdata, stack_top_entry, status_reg, mr, ph, pc_reg;
    logic [3:0] sv;
    logic [7:0] chain;
    logic [15:0] pc_exp = 16'h0000;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    // ==========
    // Design and memories; pointer and stack sources held fixed
    wmx_exec u_dut (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cond_true(cond_true),
        .cmd_ready(cmd_ready), .done(done), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
        .dflag_rdata(dflag_rdata), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .data_pointer_reg(16'h3C96), .stack_top_in(16'h6A17), .stack_top_wr(stack_top_wr),
        .stack_top_entry(stack_top_entry), .status_reg(status_reg), .multiplier_operand_reg(mr),
        .product_high_reg(ph), .shift_amount_reg(sv), .chain_length_reg(chain), .pc_reg(pc_reg));
    wmx_mem_model u_mem (.ref_clk(ref_clk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
        .dflag_rdata(dflag_rdata), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            fails++;
        end
    endtask
    task close_out;
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One command; fl is {alt, step, down, flag select}; odd codes take two words
    task automatic run(input wmx_op_t op, input logic [1:0] acc, input logic [3:0] fl, input logic [15:0] imm);
        int n = 0;
        cmd_valid <= 1'b1;
        cmd <= '{op, acc, fl[3], fl[2], fl[1], 3'h5, fl[0], 2'(op[0]) + 2'h1, imm};
        do @(posedge ref_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        pc_exp = pc_exp + 16'(op[0]) + 16'h0001;
        do begin
            @(posedge ref_clk);
            n++;
        end while (done !== 1'b1 && n < 6);
        last_req = dmem_req;
        chk("done", 16'h0001, 16'(done));
        chk("pc", pc_exp, pc_reg);
    endtask
    // Store to word 3 and compare what went out
    task automatic st(input wmx_op_t op, input logic [1:0] acc, input logic [3:0] fl, input logic [15:0] e);
        run(op, acc, fl, 16'h0003);
        chk("wr", 16'h0001, 16'(last_req.wr));
        chk("addr", 16'h0003, last_req.addr);
        chk(op.name(), e, last_req.wdata);
    endtask
    // Park a word in data memory through pointer one, which selects accumulator zero
    task automatic put(input logic [15:0] a, input logic [15:0] v);
        run(WMX_ACC_LD_IMM, 2'h1, 4'h0, v);
        run(WMX_ACC_ST_MEM, 2'h1, 4'h0, a);
    endtask
    // Cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            close_out();
        end
    end
    // ==========
    // Sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        chk("stat", 16'h0000, status_reg);
        chk("ready", 16'h0001, 16'(cmd_ready));
        run(WMX_ACC_LD_IMM, 2'h0, 4'h0, 16'hF200);
        chk("zf", 16'h0000, status_reg);
        run(WMX_ACC_LD_IMM, 2'h0, 4'h4, 16'h0000);
        chk("zf", 16'h0004, status_reg);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h0, 16'h0000);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h6, 16'hF200);
        run(WMX_ALT_FROM_ACC, 2'h0, 4'h0, 16'h0000);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h8, 16'hF200);
        run(WMX_ACC_LD_IMM, 2'h0, 4'h8, 16'h0BCD);
        run(WMX_ACC_FROM_ALT, 2'h0, 4'h0, 16'h0000);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h0, 16'h0BCD);
        run(WMX_SV_FROM_ACC, 2'h0, 4'h0, 16'h0000);
        chk("sv", 16'h000D, 16'(sv));
        run(WMX_SV_LD_IMM, 2'h0, 4'h0, 16'h0037);
        chk("sv", 16'h0007, 16'(sv));
        st(WMX_SV_ST_MEM, 2'h0, 4'h0, 16'h0007);
        // Status whole, then signed mode from memory and from accumulator
        put(16'h0004, 16'hFFFF);
        run(WMX_STAT_LD_MEM, 2'h0, 4'h0, 16'h0004);
        chk("stat", 16'hFFFF, status_reg);
        run(WMX_MR_LD_MEM, 2'h0, 4'h0, 16'h0004);
        chk("um", 16'hFFFD, status_reg);
        run(WMX_STAT_LD_MEM, 2'h0, 4'h0, 16'h0004);
        run(WMX_ACC_LD_IMM, 2'h0, 4'h0, 16'h2468);
        run(WMX_MR_FROM_ACC, 2'h0, 4'h0, 16'h0000);
        chk("mr", 16'h2468, mr);
        chk("um", 16'hFFF9, status_reg);
        st(WMX_STAT_ST_MEM, 2'h0, 4'h0, 16'hFFF9);
        // Pointer width limits, on pointer three
        put(16'h0005, 16'hFFC5);
        run(WMX_AP_LD_MEM, 2'h3, 4'h0, 16'h0005);
        st(WMX_AP_ST_MEM, 2'h3, 4'h0, 16'h0005);
        run(WMX_AP_LD_IMM, 2'h3, 4'h0, 16'hFFF7);
        st(WMX_AP_ST_MEM, 2'h3, 4'h0, 16'h0017);
        put(16'h0006, 16'h12C9);
        run(WMX_CHAIN_LD_MEM, 2'h0, 4'h0, 16'h0006);
        chk("chain", 16'h00C9, 16'(chain));
        st(WMX_CHAIN_ST_MEM, 2'h0, 4'h0, 16'h00C9);
        run(WMX_SV_LD_MEM, 2'h0, 4'h0, 16'h0006);
        chk("sv", 16'h0009, 16'(sv));
        put(16'h0007, 16'h5A5A);
        run(WMX_PH_LD_MEM, 2'h0, 4'h0, 16'h0007);
        chk("ph", 16'h5A5A, ph);
        run(WMX_ACC_LD_IMM, 2'h0, 4'h0, 16'h0F0F);
        run(WMX_PH_FROM_ACC, 2'h0, 4'h0, 16'h0000);
        chk("ph", 16'h0F0F, ph);
        run(WMX_ACC_LD_IMM, 2'h0, 4'h0, 16'h0000);
        run(WMX_ACC_FROM_PH, 2'h0, 4'h0, 16'h0000);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h0, 16'h0F0F);
        st(WMX_DP_ST_MEM, 2'h0, 4'h0, 16'h3C96);
        put(16'h0008, 16'h7E81);
        run(WMX_TOS_LD_MEM, 2'h0, 4'h0, 16'h0008);
        chk("tos", 16'h7E81, stack_top_entry);
        st(WMX_TOS_ST_MEM, 2'h0, 4'h0, 16'h6A17);
        // Table forms: program word is address xor 5A3C
        run(WMX_ACC_LD_IMM, 2'h0, 4'h0, 16'h0042);
        st(WMX_TABLE_TO_MEM, 2'h0, 4'h0, 16'h5A7E);
        run(WMX_TABLE_TO_ACC, 2'h0, 4'h0, 16'h0000);
        st(WMX_ACC_ST_MEM, 2'h0, 4'h0, 16'h5A7E);
        run(WMX_IDX_LD_IMM, 2'h0, 4'h0, 16'h9C3E);
        st(WMX_IDX_ST_MEM, 2'h0, 4'h0, 16'h9C3E);
        // Test flags from a clear status word
        put(16'h0009, 16'h0000);
        run(WMX_STAT_LD_MEM, 2'h0, 4'h0, 16'h0009);
        cond_true <= 1'b1;
        run(WMX_TF_FROM_COND, 2'h0, 4'h0, 16'h0000);
        chk("tf", 16'h0010, status_reg);
        run(WMX_TF_ST_FLAG, 2'h0, 4'h0, 16'h0003);
        chk("flag", 16'h0003, {last_req.flag, last_req.wdata[0]});
        cond_true <= 1'b0;
        run(WMX_TF_FROM_COND, 2'h0, 4'h0, 16'h0000);
        chk("tf", 16'h0000, status_reg);
        run(WMX_TF_LD_FLAG, 2'h0, 4'h0, 16'h0003);
        chk("tf", 16'h0010, status_reg);
        cond_true <= 1'b1;
        run(WMX_TF_FROM_COND, 2'h0, 4'h1, 16'h0000);
        chk("tf", 16'h0030, status_reg);
        // Second reset in mid-run, then one more load
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        pc_exp = 16'h0000;
        chk("stat", 16'h0000, status_reg);
        chk("pc", 16'h0000, pc_reg);
        run(WMX_MR_LD_IMM, 2'h0, 4'h0, 16'h4B2D);
        chk("mr", 16'h4B2D, mr);
        close_out();
    end
endmodule

// ===== verification/wmx_mem_model.sv
/*
 Behavioural data, flag and program memory facing the copy executor.
 Assumes registered requests; read data answers within the request cycle.
*/
`timescale 1ns/1ps
module wmx_mem_model
    import wmx_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Data and flag memory
    input wire wmx_mem_t dmem_req,
    output logic [15:0] dmem_rdata,
    output logic dflag_rdata,
    // Program memory
    input wire logic pmem_rd,
    input wire logic [15:0] pmem_addr,
    output logic [15:0] pmem_rdata
);
    // Sixteen words and flags are enough for the bench
    logic [15:0] mem [16];
    logic [15:0] flg;
    wire [3:0] a = dmem_req.addr[3:0];
    // Lines not read show the inverse, so stale data never passes
    assign dmem_rdata = dmem_req.rd ? mem[a] : ~mem[a];
    assign dflag_rdata = (dmem_req.rd && dmem_req.flag) ? flg[a] : ~flg[a];
    // Program word is a fixed scramble of its address
    assign pmem_rdata = pmem_rd ? (pmem_addr ^ 16'h5A3C) : ~(pmem_addr ^ 16'h5A3C);
    // Writes land on the edge after the request
    always @(posedge ref_clk) begin
        if (dmem_req.wr && dmem_req.flag) begin
            flg[a] <= dmem_req.wdata[0];
        end else if (dmem_req.wr) begin
            mem[a] <= dmem_req.wdata;
        end
    end
endmodule
